// ---- core/ptgm_regs.vh ----
// Purpose: Constants for the packet traffic generator and monitor.
// Assumes: Included by core/ptgm_top.v only.
// Notes: Offsets are byte addresses on the plain register port.
`ifndef PTGM_REGS_VH
`define PTGM_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PTGM_OFS_PKT_CNT 8'h00
`define PTGM_OFS_CTRL 8'h04
`define PTGM_OFS_STATUS 8'h08
`define PTGM_OFS_RX_CNT 8'h0C
`define PTGM_OFS_TX_CNT 8'h10
// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define PTGM_CTRL_BURST 0
`define PTGM_CTRL_INBAND_FC 1
`define PTGM_CTRL_OUTOFBAND_FC 2
`define PTGM_CTRL_ERRINJ 3
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define PTGM_ST_TX_DONE 0
`define PTGM_ST_TX_FAIL 1
`define PTGM_ST_TX_BUSY 2
`define PTGM_ST_RX_BUSY 3
`define PTGM_ST_RX_DONE 4
`define PTGM_ST_RX_ERR 5
`define PTGM_ST_CFG_BAD 6
`define PTGM_ST_INBAND_FC_ERR 7
`define PTGM_ST_OUTOFBAND_FC_ERR 8
`define PTGM_ST_ERRINJ 9
`define PTGM_ST_LOCKED 10
`define PTGM_ST_ALIGNED 11
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PTGM_PKT_CNT_RST 16'h000A
`define PTGM_PKT_MIN 16'h0002
`define PTGM_PKT_MAX 16'hFFFE
`define PTGM_PKT_SEGS 3'h5
`define PTGM_CHAN_A 8'h00
`define PTGM_CHAN_B 8'h01
`endif

// ---- core/ptgm_top.v ----
// Purpose: Traffic generator and monitor on a segmented user bus, with bit swap stage.
// Assumes: Core bus and registers share clock_in; user pins are asynchronous.
// Notes: Loopback traffic is checked against the same pattern the generator sends.
//
// What this block does
// - Packet count even, from 2 to 65534.
// - Generator and monitor share one packet count.
// - Generator sends only after lock and alignment.
// - Monitor accepts only after lock and alignment.
// - Coordinate by lock, alignment and bus handshake.
// - Packet mode: channel counts 0 to 255, wraps.
// - Burst mode: channel alternates between two values.
// - Fixed length moves SOP/EOP over every segment.
// - Drive flow-control and error-injection controls.
// - Monitor flow-control and error-injection status.
// - Reverse bit order both data directions.
// - Low rate: one clock for core and bus.
// - Restart acts only when both sides idle.
// - Done once all packets are sent.
// - Fail on transmit FIFO overflow or underflow.
// - User controls and status pass three registers; lock and alignment outputs pass four.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "ptgm_regs.vh"

// ----------------------------------------
// FIFO
// ----------------------------------------
module ptgm_fifo #(
	parameter W = 8,
	parameter D = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clock_in,
	input wire rst_n_in,
	// Fill side
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [W-1:0] in_data_in,
	// Drain side
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [W-1:0] out_data_out
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire do_wr;
	wire do_rd;
	assign in_ready_out = (count_r != D);
	assign out_valid_out = (count_r != 0);
	assign out_data_out = mem[rd_ptr_r];
	assign do_wr = in_valid_in & in_ready_out;
	assign do_rd = out_valid_out & out_ready_in;
	always @(posedge clock_in) begin
		if (do_wr) begin
			mem[wr_ptr_r] <= in_data_in;
		end
	end
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr_r <= (wr_ptr_r == D - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_r <= (rd_ptr_r == D - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
		end
	end
endmodule // ptgm_fifo

// ----------------------------------------
// Top
// ----------------------------------------
module ptgm_top #(
	parameter SEGS = 4,
	parameter LW = 64,
	parameter FIFO_D = 16,
	parameter FIFO_AW = 4
) (
	// Clock and reset
	input wire clock_in,
	input wire rst_n_in,
	// Register port
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	// User pins
	input wire restart_in,
	input wire gt_locked_in,
	input wire rx_aligned_in,
	output reg tx_done_out,
	output reg tx_fail_out,
	output reg tx_busy_out,
	output reg rx_busy_out,
	output reg rx_done_out,
	output reg rx_err_out,
	output reg gt_locked_out,
	output reg rx_aligned_out,
	// Transmit user bus
	output reg [SEGS*32-1:0] tx_data_out,
	output reg [SEGS-1:0] tx_ena_out,
	output reg [SEGS-1:0] tx_sop_out,
	output reg [SEGS-1:0] tx_eop_out,
	output reg [SEGS*8-1:0] tx_chan_out,
	input wire tx_rdy_in,
	// Receive user bus
	input wire [SEGS*32-1:0] rx_data_in,
	input wire [SEGS-1:0] rx_ena_in,
	input wire [SEGS-1:0] rx_sop_in,
	input wire [SEGS-1:0] rx_eop_in,
	input wire [SEGS*8-1:0] rx_chan_in,
	// Flow control and error injection
	output reg inband_flow_ctrl_en_out,
	output reg outofband_flow_ctrl_en_out,
	output reg err_inj_out,
	input wire inband_flow_ctrl_err_in,
	input wire outofband_flow_ctrl_err_in,
	input wire err_inj_stat_in,
	// Swap stage
	input wire [LW-1:0] core_tx_ser_in,
	output reg [LW-1:0] ser_tx_out,
	input wire [LW-1:0] ser_rx_in,
	output reg [LW-1:0] core_rx_ser_out
);
	localparam SW = 32 + 8 + 3;
	localparam FW = SEGS * SW;
	localparam G_IDLE = 2'h0;
	localparam G_WAIT = 2'h1;
	localparam G_SEND = 2'h2;
	localparam G_DONE = 2'h3;

	function [LW-1:0] bit_rev;
		input [LW-1:0] v;
		integer i;
		begin
			for (i = 0; i < LW; i = i + 1) begin
				bit_rev[i] = v[LW-1-i];
			end
		end
	endfunction

	function [31:0] seg_pat;
		input [15:0] p;
		input [2:0] s;
		begin
			seg_pat = {p, ~p[12:0], s};
		end
	endfunction

	function [7:0] chan_of;
		input [15:0] p;
		input burst;
		begin
			if (burst) begin
				chan_of = p[0] ? `PTGM_CHAN_B : `PTGM_CHAN_A;
			end else begin
				chan_of = p[7:0];
			end
		end
	endfunction

	// ----------------------------------------
	// Input and status pipelines
	// ----------------------------------------
	reg [2:0] restart_p_r;
	reg [2:0] locked_p_r;
	reg [2:0] aligned_p_r;
	reg [5:0] st_p1_r;
	reg [5:0] st_p2_r;
	wire link_up;
	wire [5:0] st_now;
	assign link_up = locked_p_r[2] & aligned_p_r[2];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [15:0] pkt_cnt_r;
	reg [3:0] ctrl_r;
	reg [1:0] gstate_r;
	reg [1:0] mstate_r;
	reg [15:0] gpkt_r;
	reg [2:0] gpos_r;
	reg [15:0] mpkt_r;
	reg [2:0] mpos_r;
	reg fail_r;
	reg merr_r;
	reg [2:0] fc_st_r;
	reg restart_d_r;
	wire cfg_ok;
	wire start;
	wire gen_busy;
	wire mon_busy;
	assign cfg_ok = ~pkt_cnt_r[0] && pkt_cnt_r >= `PTGM_PKT_MIN && pkt_cnt_r <= `PTGM_PKT_MAX;
	assign gen_busy = (gstate_r == G_WAIT) || (gstate_r == G_SEND);
	assign mon_busy = (mstate_r == G_WAIT) || (mstate_r == G_SEND);
	assign start = restart_p_r[2] & ~restart_d_r & ~gen_busy & ~mon_busy & cfg_ok;

	// ----------------------------------------
	// Generator beat builder
	// ----------------------------------------
	reg [FW-1:0] gbeat;
	reg [15:0] gp_nxt;
	reg [2:0] gs_nxt;
	integer k;
	always @* begin
		gbeat = {FW{1'b0}};
		gp_nxt = gpkt_r;
		gs_nxt = gpos_r;
		for (k = 0; k < SEGS; k = k + 1) begin
			if (gp_nxt < pkt_cnt_r) begin
				gbeat[k*SW +: SW] = {seg_pat(gp_nxt, gs_nxt), chan_of(gp_nxt, ctrl_r[`PTGM_CTRL_BURST]),
					1'b1, gs_nxt == 3'h0, gs_nxt == `PTGM_PKT_SEGS - 3'h1};
				if (gs_nxt == `PTGM_PKT_SEGS - 3'h1) begin
					gs_nxt = 3'h0;
					gp_nxt = gp_nxt + 16'h0001;
				end else begin
					gs_nxt = gs_nxt + 3'h1;
				end
			end
		end
	end

	wire f_in_ready;
	wire f_out_valid;
	wire [FW-1:0] f_out_data;
	wire gen_wr;
	wire tx_load;
	wire tx_full;
	assign gen_wr = (gstate_r == G_SEND) && (gpkt_r < pkt_cnt_r);
	assign tx_full = |tx_ena_out;
	assign tx_load = ~tx_full | tx_rdy_in;

	ptgm_fifo #(
		.W(FW),
		.D(FIFO_D),
		.AW(FIFO_AW)
	) u_fifo (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(gen_wr),
		.in_ready_out(f_in_ready),
		.in_data_in(gbeat),
		.out_valid_out(f_out_valid),
		.out_ready_in(tx_load),
		.out_data_out(f_out_data)
	);

	// ----------------------------------------
	// Monitor beat checker
	// ----------------------------------------
	reg [15:0] mp_nxt;
	reg [2:0] ms_nxt;
	reg mbad;
	integer j;
	always @* begin
		mp_nxt = mpkt_r;
		ms_nxt = mpos_r;
		mbad = 1'b0;
		for (j = 0; j < SEGS; j = j + 1) begin
			if (rx_ena_in[j]) begin
				if (mp_nxt >= pkt_cnt_r || rx_data_in[j*32 +: 32] != seg_pat(mp_nxt, ms_nxt) ||
					rx_chan_in[j*8 +: 8] != chan_of(mp_nxt, ctrl_r[`PTGM_CTRL_BURST]) ||
					rx_sop_in[j] != (ms_nxt == 3'h0) ||
					rx_eop_in[j] != (ms_nxt == `PTGM_PKT_SEGS - 3'h1)) begin
					mbad = 1'b1;
				end
				if (ms_nxt == `PTGM_PKT_SEGS - 3'h1) begin
					ms_nxt = 3'h0;
					mp_nxt = mp_nxt + 16'h0001;
				end else begin
					ms_nxt = ms_nxt + 3'h1;
				end
			end
		end
	end

	assign st_now = {merr_r, mstate_r == G_DONE, mon_busy, gen_busy, fail_r, gstate_r == G_DONE};

	// ----------------------------------------
	// Sequential logic
	// ----------------------------------------
	integer n;
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			restart_p_r <= 3'h0;
			locked_p_r <= 3'h0;
			aligned_p_r <= 3'h0;
			restart_d_r <= 1'b0;
			st_p1_r <= 6'h00;
			st_p2_r <= 6'h00;
			pkt_cnt_r <= `PTGM_PKT_CNT_RST;
			ctrl_r <= 4'h0;
			gstate_r <= G_IDLE;
			mstate_r <= G_IDLE;
			gpkt_r <= 16'h0000;
			gpos_r <= 3'h0;
			mpkt_r <= 16'h0000;
			mpos_r <= 3'h0;
			fail_r <= 1'b0;
			merr_r <= 1'b0;
			fc_st_r <= 3'h0;
			reg_rdata_out <= 32'h00000000;
			tx_done_out <= 1'b0;
			tx_fail_out <= 1'b0;
			tx_busy_out <= 1'b0;
			rx_busy_out <= 1'b0;
			rx_done_out <= 1'b0;
			rx_err_out <= 1'b0;
			gt_locked_out <= 1'b0;
			rx_aligned_out <= 1'b0;
			tx_data_out <= {(SEGS*32){1'b0}};
			tx_ena_out <= {SEGS{1'b0}};
			tx_sop_out <= {SEGS{1'b0}};
			tx_eop_out <= {SEGS{1'b0}};
			tx_chan_out <= {(SEGS*8){1'b0}};
			inband_flow_ctrl_en_out <= 1'b0;
			outofband_flow_ctrl_en_out <= 1'b0;
			err_inj_out <= 1'b0;
			ser_tx_out <= {LW{1'b0}};
			core_rx_ser_out <= {LW{1'b0}};
		end else begin
			restart_p_r <= {restart_p_r[1:0], restart_in};
			locked_p_r <= {locked_p_r[1:0], gt_locked_in};
			aligned_p_r <= {aligned_p_r[1:0], rx_aligned_in};
			restart_d_r <= restart_p_r[2];
			st_p1_r <= st_now;
			st_p2_r <= st_p1_r;
			{rx_err_out, rx_done_out, rx_busy_out, tx_busy_out, tx_fail_out, tx_done_out} <= st_p2_r;
			gt_locked_out <= locked_p_r[2];
			rx_aligned_out <= aligned_p_r[2];
			if (reg_wr_in) begin
				if (reg_addr_in == `PTGM_OFS_PKT_CNT) begin
					pkt_cnt_r <= reg_wdata_in[15:0];
				end else if (reg_addr_in == `PTGM_OFS_CTRL) begin
					ctrl_r <= reg_wdata_in[3:0];
				end
			end
			if (reg_rd_in) begin
				if (reg_addr_in == `PTGM_OFS_PKT_CNT) begin
					reg_rdata_out <= {16'h0000, pkt_cnt_r};
				end else if (reg_addr_in == `PTGM_OFS_CTRL) begin
					reg_rdata_out <= {28'h0000000, ctrl_r};
				end else if (reg_addr_in == `PTGM_OFS_STATUS) begin
					reg_rdata_out <= {20'h00000, aligned_p_r[2], locked_p_r[2], fc_st_r, ~cfg_ok, st_now};
				end else if (reg_addr_in == `PTGM_OFS_RX_CNT) begin
					reg_rdata_out <= {16'h0000, mpkt_r};
				end else if (reg_addr_in == `PTGM_OFS_TX_CNT) begin
					reg_rdata_out <= {16'h0000, gpkt_r};
				end else begin
					reg_rdata_out <= 32'h00000000;
				end
			end else begin
				reg_rdata_out <= 32'h00000000;
			end
			inband_flow_ctrl_en_out <= ctrl_r[`PTGM_CTRL_INBAND_FC] & gen_busy;
			outofband_flow_ctrl_en_out <= ctrl_r[`PTGM_CTRL_OUTOFBAND_FC] & gen_busy;
			err_inj_out <= ctrl_r[`PTGM_CTRL_ERRINJ] & (gstate_r == G_SEND);
			fc_st_r <= (start ? 3'h0 : fc_st_r) | {err_inj_stat_in, outofband_flow_ctrl_err_in,
				inband_flow_ctrl_err_in};
			ser_tx_out <= bit_rev(core_tx_ser_in);
			core_rx_ser_out <= bit_rev(ser_rx_in);
			if (tx_load) begin
				for (n = 0; n < SEGS; n = n + 1) begin
					tx_data_out[n*32 +: 32] <= f_out_data[n*SW+11 +: 32];
					tx_chan_out[n*8 +: 8] <= f_out_data[n*SW+3 +: 8];
					tx_ena_out[n] <= f_out_valid & f_out_data[n*SW+2];
					tx_sop_out[n] <= f_out_valid & f_out_data[n*SW+1];
					tx_eop_out[n] <= f_out_valid & f_out_data[n*SW];
				end
			end
			case (gstate_r)
				G_WAIT: begin
					if (link_up) begin
						gstate_r <= G_SEND;
					end
				end
				G_SEND: begin
					if (gen_wr && f_in_ready) begin
						gpkt_r <= gp_nxt;
						gpos_r <= gs_nxt;
					end
					// A full FIFO is normal back-pressure; it is an overflow only
					// when the output stage is empty and could have drained it.
					if (gen_wr && !f_in_ready && !tx_full) begin
						fail_r <= 1'b1;
					end else if (f_out_valid == 1'b0 && tx_load && gpos_r != 3'h0) begin
						fail_r <= 1'b1;
					end
					if (!gen_wr && !f_out_valid && !tx_full) begin
						gstate_r <= G_DONE;
					end
				end
				default: begin
					if (start) begin
						gstate_r <= G_WAIT;
						gpkt_r <= 16'h0000;
						gpos_r <= 3'h0;
						fail_r <= 1'b0;
					end
				end
			endcase
			case (mstate_r)
				G_WAIT: begin
					if (link_up) begin
						mstate_r <= G_SEND;
					end
				end
				G_SEND: begin
					mpkt_r <= mp_nxt;
					mpos_r <= ms_nxt;
					if (mbad) begin
						merr_r <= 1'b1;
					end
					if (mp_nxt >= pkt_cnt_r) begin
						mstate_r <= G_DONE;
					end
				end
				default: begin
					if (start) begin
						mstate_r <= G_WAIT;
						mpkt_r <= 16'h0000;
						mpos_r <= 3'h0;
						merr_r <= 1'b0;
					end
					if (mstate_r == G_DONE && |rx_ena_in) begin
						merr_r <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule // ptgm_top

// ---- test/ptgm_top_asserts.sv ----
// Purpose: Port-level assertions for the traffic generator and monitor.
// Assumes: One clock domain; bound into every ptgm_top instance.
// Notes: A restart age counter bounds when busy may rise.
module ptgm_top_asserts #(
	parameter SEGS = 4,
	parameter LW = 64
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// User pins
	input wire logic restart_in,
	input wire logic gt_locked_in,
	input wire logic rx_aligned_in,
	input wire logic tx_busy_out,
	input wire logic gt_locked_out,
	input wire logic rx_aligned_out,
	// Transmit bus
	input wire logic [SEGS*32-1:0] tx_data_out,
	input wire logic [SEGS-1:0] tx_ena_out,
	input wire logic [SEGS-1:0] tx_sop_out,
	input wire logic [SEGS-1:0] tx_eop_out,
	input wire logic tx_rdy_in,
	// Swap stage
	input wire logic [LW-1:0] core_tx_ser_in,
	input wire logic [LW-1:0] ser_tx_out,
	input wire logic [LW-1:0] ser_rx_in,
	input wire logic [LW-1:0] core_rx_ser_out
);
	// ------
	// Helpers
	// ------
	logic [LW-1:0] rev_tx, rev_rx;
	logic [3:0] age_r;
	always_comb begin
		for (int i = 0; i < LW; i++) begin
			rev_tx[i] = core_tx_ser_in[LW-1-i];
			rev_rx[i] = ser_rx_in[LW-1-i];
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) age_r <= 4'hF;
		else if (restart_in) age_r <= 4'h0;
		else if (age_r != 4'hF) age_r <= age_r + 4'h1;
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// ------
	// Properties
	// ------
	property p_swap_tx; 1'h1 |=> ser_tx_out == $past(rev_tx); endproperty
	a_swap_tx: assert property (p_swap_tx) else $error("tx swap wrong");
	property p_swap_rx; 1'h1 |=> core_rx_ser_out == $past(rev_rx); endproperty
	a_swap_rx: assert property (p_swap_rx) else $error("rx swap wrong");
	property p_hold; tx_ena_out != '0 && !tx_rdy_in |=> $stable(tx_data_out) &&
		$stable(tx_ena_out) && $stable(tx_sop_out) && $stable(tx_eop_out); endproperty
	a_hold: assert property (p_hold) else $error("beat changed while stalled");
	property p_lock; gt_locked_in [*6] |-> gt_locked_out; endproperty
	a_lock: assert property (p_lock) else $error("lock status lost");
	property p_align; !rx_aligned_in [*6] |-> !rx_aligned_out; endproperty
	a_align: assert property (p_align) else $error("align status stuck");
	property p_start; $rose(tx_busy_out) |-> age_r <= 4'hC; endproperty
	a_start: assert property (p_start) else $error("busy without restart");
	property p_ena; tx_ena_out != '0 |-> ((tx_ena_out + 1'h1) & tx_ena_out) == '0; endproperty
	a_ena: assert property (p_ena) else $error("segments not packed");
	property p_mark; ##0 ((tx_sop_out | tx_eop_out) & ~tx_ena_out) == '0; endproperty
	a_mark: assert property (p_mark) else $error("marker on idle segment");
endmodule // ptgm_top_asserts

bind ptgm_top ptgm_top_asserts #(.SEGS(SEGS), .LW(LW)) i_ptgm_top_asserts (.*);

// ---- test/ptgm_core_model.sv ----
// Purpose: Loopback stand-in for the protocol core user bus.
// Assumes: Same clock as the tester; stall and corrupt come from the bench.
// Notes: Beats are {data, ena, sop, eop, chan}; taken beats return in order.
module ptgm_core_model #(
	parameter SEGS = 4
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Bench controls
	input wire logic stall_in,
	input wire logic corrupt_in,
	// Transmit side
	input wire logic [SEGS*43-1:0] tx_beat_in,
	output logic tx_rdy_out,
	// Receive side
	output logic [SEGS*43-1:0] rx_beat_out
);
	logic [SEGS*43-1:0] q[$];
	logic [SEGS*43-1:0] v;
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q.delete();
			tx_rdy_out <= 1'h0;
			rx_beat_out <= '0;
		end else begin
			if (tx_rdy_out && tx_beat_in[SEGS*10+:SEGS] != '0) q.push_back(tx_beat_in);
			tx_rdy_out <= !stall_in;
			if (q.size() > 0 && !stall_in) begin
				v = q.pop_front();
				v[SEGS*11] = v[SEGS*11] ^ corrupt_in;
			end else begin
				v = ~rx_beat_out;
				v[SEGS*8+:SEGS*3] = '0;
			end
			rx_beat_out <= v;
		end
	end
endmodule // ptgm_core_model

// ---- test/ptgm_top_bench.sv ----
// Purpose: Self-checking bench for the traffic generator and monitor.
// Assumes: The core model loops transmit beats back to the receive bus.
// Notes: Expected segments come from a count-based model of the pattern.
module ptgm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SEGS = 4;
	logic clock_in = 1'h0, rst_n_in = 1'h0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'h0, reg_rd_in = 1'h0, restart_in = 1'h0;
	logic gt_locked_in = 1'h0, rx_aligned_in = 1'h0;
	logic inband_flow_ctrl_err_in = 1'h0, outofband_flow_ctrl_err_in = 1'h0;
	logic err_inj_stat_in = 1'h0, stall = 1'h0, corrupt = 1'h0, slow = 1'h0;
	logic [63:0] core_tx_ser_in = 64'h0, ser_rx_in = 64'h0, sw, rv;
	logic [31:0] reg_rdata_out;
	logic tx_done_out, tx_fail_out, tx_busy_out, rx_busy_out, rx_done_out, rx_err_out;
	logic gt_locked_out, rx_aligned_out, tx_rdy_in, burst_m;
	logic [SEGS*32-1:0] tx_data_out;
	logic [SEGS-1:0] tx_ena_out, tx_sop_out, tx_eop_out;
	logic [SEGS*8-1:0] tx_chan_out;
	logic inband_flow_ctrl_en_out, outofband_flow_ctrl_en_out, err_inj_out;
	logic [63:0] ser_tx_out, core_rx_ser_out;
	logic [SEGS*43-1:0] rx_beat;
	logic [41:0] got;
	logic [2:0] fc;
	wire [SEGS*32-1:0] rx_data_in = rx_beat[SEGS*11+:SEGS*32];
	wire [SEGS-1:0] rx_ena_in = rx_beat[SEGS*10+:SEGS];
	wire [SEGS-1:0] rx_sop_in = rx_beat[SEGS*9+:SEGS];
	wire [SEGS-1:0] rx_eop_in = rx_beat[SEGS*8+:SEGS];
	wire [SEGS*8-1:0] rx_chan_in = rx_beat[SEGS*8-1:0];
	int seed = 32'h92E6, error_cnt = 0, samples_checked = 0, seg_i = 0;
	int bad_n[3] = '{0, 1, 65535};
	ptgm_top #(.SEGS(SEGS), .LW(64)) i_ptgm_top (.*);
	ptgm_core_model #(.SEGS(SEGS)) i_ptgm_core_model (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.stall_in(stall), .corrupt_in(corrupt), .tx_rdy_out(tx_rdy_in), .rx_beat_out(rx_beat),
		.tx_beat_in({tx_data_out, tx_ena_out, tx_sop_out, tx_eop_out, tx_chan_out}));
	always #5 clock_in = ~clock_in;
	always @(posedge clock_in) stall <= slow ? 1'($random(seed)) : 1'h0;
	// ------
	// Model and compares
	// ------
	function automatic logic [41:0] exp_seg(input int k);
		int p, s;
		p = k / 5;
		s = k % 5;
		exp_seg = {p[15:0], ~p[12:0], s[2:0], s == 0, s == 4, burst_m ? {7'h0, p[0]} : p[7:0]};
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_seg(input logic [41:0] g, input logic [41:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: segment %h expected %h", $time, g, e);
		end
	endtask
	always @(posedge clock_in) begin
		if (rst_n_in && tx_rdy_in && tx_ena_out != '0) begin
			for (int n = 0; n < SEGS; n++) begin
				if (tx_ena_out[n]) begin
					got = {tx_data_out[n*32+:32], tx_sop_out[n], tx_eop_out[n], tx_chan_out[n*8+:8]};
					chk_seg(got, exp_seg(seg_i));
					seg_i++;
				end
			end
		end
	end
	// ------
	// Bus and run tasks
	// ------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'h1;
		@(posedge clock_in);
		reg_wr_in <= 1'h0;
		@(posedge clock_in);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		reg_addr_in <= a;
		reg_rd_in <= 1'h1;
		@(posedge clock_in);
		reg_rd_in <= 1'h0;
		#1 chk(reg_rdata_out & m, e);
		@(posedge clock_in);
	endtask
	task automatic start(input int n, input logic [3:0] c, input logic bad);
		wr(8'h00, n);
		wr(8'h04, {28'h0, c});
		burst_m = c[0];
		seg_i = 0;
		corrupt <= bad;
		restart_in <= 1'h1;
		repeat (4) @(posedge clock_in);
		restart_in <= 1'h0;
		repeat (12) @(posedge clock_in);
	endtask
	task automatic finish(input int n, input logic [3:0] c, input logic bad);
		int k;
		for (k = 0; k < 30000 && !(tx_done_out === 1'h1 && (rx_done_out === 1'h1 || bad)); k++) begin
			if (k == 40) chk({err_inj_out, outofband_flow_ctrl_en_out, inband_flow_ctrl_en_out}, c[3:1]);
			if (k == 60) restart_in <= 1'h1;
			if (k == 64) restart_in <= 1'h0;
			@(posedge clock_in);
		end
		restart_in <= 1'h0;
		repeat (20) @(posedge clock_in);
		chk(seg_i, 5 * n);
		chk({tx_done_out, tx_busy_out, rx_busy_out, tx_fail_out, rx_err_out}, {4'h8, bad});
		chk({err_inj_out, outofband_flow_ctrl_en_out, inband_flow_ctrl_en_out}, 3'h0);
		if (!bad) chk(rx_done_out, 1'h1);
		rdc(8'h0C, 32'hFFFFFFFF, n);
		rdc(8'h10, 32'hFFFFFFFF, n);
		corrupt <= 1'h0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ------
	// Tests
	// ------
	initial begin
		repeat (6) @(posedge clock_in);
		rst_n_in <= 1'h1;
		@(posedge clock_in);
		rdc(8'h00, 32'hFFFFFFFF, 32'h0000000A);
		rdc(8'h04, 32'hFFFFFFFF, 32'h0);
		wr(8'h14, 32'hFFFFFFFF);
		rdc(8'h14, 32'hFFFFFFFF, 32'h0);
		rdc(8'h00, 32'hFFFFFFFF, 32'h0000000A);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			sw = {$random(seed), $random(seed)};
			core_tx_ser_in <= sw;
			ser_rx_in <= ~sw;
			@(posedge clock_in);
			#1 rv = {<<{sw}};
			chk(ser_tx_out, rv);
			rv = {<<{~sw}};
			chk(core_rx_ser_out, rv);
			@(posedge clock_in);
		end
		$display("test swap done");
		foreach (bad_n[i]) begin
			start(bad_n[i], 4'h0, 1'h0);
			chk(tx_busy_out, 1'h0);
			rdc(8'h08, 32'h40, 32'h40);
		end
		$display("test bad count done");
		start(2, 4'h0, 1'h0);
		repeat (40) @(posedge clock_in);
		chk(seg_i, 0);
		gt_locked_in <= 1'h1;
		repeat (40) @(posedge clock_in);
		chk(seg_i, 0);
		rx_aligned_in <= 1'h1;
		finish(2, 4'h0, 1'h0);
		$display("test link wait done");
		slow = 1'h1;
		fc = 3'($random(seed));
		start(260, {fc, 1'h0}, 1'h0);
		finish(260, {fc, 1'h0}, 1'h0);
		start(6, 4'h1, 1'h0);
		finish(6, 4'h1, 1'h0);
		slow = 1'h0;
		$display("test traffic modes done");
		for (int i = 0; i < 3; i++) begin
			{err_inj_stat_in, outofband_flow_ctrl_err_in, inband_flow_ctrl_err_in} <= 3'h1 << i;
			@(posedge clock_in);
			{err_inj_stat_in, outofband_flow_ctrl_err_in, inband_flow_ctrl_err_in} <= 3'h0;
			repeat (3) @(posedge clock_in);
			rdc(8'h08, 32'h380, (32'h100 << i) - 32'h80);
		end
		$display("test status flags done");
		start(2, 4'h0, 1'h1);
		finish(2, 4'h0, 1'h1);
		$display("test corrupt data done");
		report_and_stop;
	end
	initial begin
		#400000;
		error_cnt++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		report_and_stop;
	end
endmodule // ptgm_top_bench
